// [hdl/ipw_timer.sv]
// three-phase complementary pwm timer with shared dead time
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - run enable low clears and halts all counters and floats the outputs.
// - clock select codes 0..5 pick system clock divided by 1 to 32.
// - divide field N raises the period interrupt every N+1 underflows.
// - read-only status flag; cleared by stop sources, never by software.
// - active level bit: 0 makes outputs active low, 1 active high.
// - edge select bit: 0 falling, 1 rising edge of the stop input.
// - external stop enabled and valid edge floats all six outputs.
// - watchdog stop enabled and watchdog request floats all six outputs.
// - after a forced stop the counters keep running while enabled.
// - pwm drive only with status and run set; else all outputs float.
// - pwm period is twice the period compare times the count clock.
// - dead time equals reload value plus one system clock periods.
// - phase widths follow the compares around the triangle, minus dead time.
// - zero or negative width keeps that output constantly inactive.
// - channel compare above period keeps the positive phase constantly inactive.
// - triangle counts up to period compare, down to zero, then underflows.
// - every buffer is copied into its compare on the period interrupt.
// - channel match reloads its dead-time counter, which parks at all ones.
module ipw_timer (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        arst_n_in,
   // register port
   input  wire logic [15:0] reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [15:0] reg_rdata_out,
   // stop sources
   input  wire logic        output_stop_input_in,
   input  wire logic        watchdog_interrupt_request_in,
   // period interrupt
   output logic             period_interrupt_out,
   // phase outputs: u pos, u neg, v pos, v neg, w pos, w neg
   output logic      [5:0]  phase_out,
   output logic      [5:0]  phase_oe_out
);
   typedef struct packed {
      logic [7:0]      ctrl;
      logic [3:0]      mode;
      logic            status;
      logic [3:0][9:0] buf_r;
      logic [3:0][9:0] cmp;
      logic [7:0]      dead;
      logic [4:0]      presc;
      logic [9:0]      tri_cnt;
      logic            up;
      logic [2:0]      div_cnt;
      logic            stop_s1;
      logic            stop_s2;
      logic            stop_s3;
      logic            irq;
      logic [15:0]     rdata;
      logic [5:0]      pwm;
      logic [5:0]      oe;
   } ipw_state_t;

   ipw_state_t st_ff;
   ipw_state_t nxt_st;

   logic       run;
   logic       tick;
   logic       underflow;
   logic       ext_edge;
   logic       stop_ev;
   logic       run_start;
   logic [2:0] want_pos;
   logic [2:0] pos_act;
   logic [2:0] neg_act;

   // count clock enable from the prescaler, 1 of 2^sel cycles, capped at 1 of 32
   function automatic logic tick_of(input logic [4:0] p,
                                    input logic [2:0] sel);
      logic [4:0] mask;
      mask = 5'((6'h01 << sel) - 6'h01);
      tick_of = ((p & mask) == mask);
   endfunction

   // 16-bit read view of a 10-bit compare or buffer
   function automatic logic [15:0] wide10(input logic [9:0] v);
      wide10 = {6'h00, v};
   endfunction

   assign run  = st_ff.ctrl[ipw_pkg::CTRL_RUN_POS];
   assign tick = run && tick_of(st_ff.presc,
                                st_ff.ctrl[ipw_pkg::CTRL_CLK_LSB +: 3]);
   assign underflow = tick && !st_ff.up && (st_ff.tri_cnt == 10'h001);

   // edge detect looks only at the second and third stages
   assign ext_edge = st_ff.mode[ipw_pkg::MODE_EDGE_POS]
                     ? (st_ff.stop_s2 && !st_ff.stop_s3)
                     : (!st_ff.stop_s2 && st_ff.stop_s3);
   assign stop_ev = (st_ff.mode[ipw_pkg::MODE_EXT_POS] && ext_edge)
                    || (st_ff.mode[ipw_pkg::MODE_WDT_POS]
                        && watchdog_interrupt_request_in);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.irq   = 1'b0;
      nxt_st.rdata = 16'h0000;
      run_start    = 1'b0;
      nxt_st.stop_s1 = output_stop_input_in;
      nxt_st.stop_s2 = st_ff.stop_s1;
      nxt_st.stop_s3 = st_ff.stop_s2;

      // register writes
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            ipw_pkg::ADDR_CTRL: begin
               if (!run && reg_wdata_in[ipw_pkg::CTRL_RUN_POS]) begin
                  // the starting write touches only run enable
                  nxt_st.ctrl[ipw_pkg::CTRL_RUN_POS] = 1'b1;
                  run_start = 1'b1;
               end else begin
                  nxt_st.ctrl = {reg_wdata_in[7], 1'b0, reg_wdata_in[5:0]};
               end
            end
            ipw_pkg::ADDR_MODE: nxt_st.mode = reg_wdata_in[3:0];
            ipw_pkg::ADDR_BUF_A: nxt_st.buf_r[0] = reg_wdata_in[9:0];
            ipw_pkg::ADDR_BUF_B: nxt_st.buf_r[1] = reg_wdata_in[9:0];
            ipw_pkg::ADDR_BUF_C: nxt_st.buf_r[2] = reg_wdata_in[9:0];
            ipw_pkg::ADDR_BUF_P: begin
               nxt_st.buf_r[ipw_pkg::PERIOD_IDX] = reg_wdata_in[9:0];
            end
            ipw_pkg::ADDR_CMP_A: begin
               if (!run) nxt_st.cmp[0] = reg_wdata_in[9:0];
            end
            ipw_pkg::ADDR_CMP_B: begin
               if (!run) nxt_st.cmp[1] = reg_wdata_in[9:0];
            end
            ipw_pkg::ADDR_CMP_C: begin
               if (!run) nxt_st.cmp[2] = reg_wdata_in[9:0];
            end
            ipw_pkg::ADDR_CMP_P: begin
               if (!run) nxt_st.cmp[ipw_pkg::PERIOD_IDX] = reg_wdata_in[9:0];
            end
            ipw_pkg::ADDR_DEADTIME: begin
               if (!run) nxt_st.dead = reg_wdata_in[7:0];
            end
            default: ;
         endcase
      end

      // register reads, data in the following cycle only
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            ipw_pkg::ADDR_CTRL:     nxt_st.rdata = {8'h00, st_ff.ctrl};
            ipw_pkg::ADDR_MODE:     nxt_st.rdata = {11'h000, st_ff.status,
                                                    st_ff.mode};
            ipw_pkg::ADDR_BUF_A:    nxt_st.rdata = wide10(st_ff.buf_r[0]);
            ipw_pkg::ADDR_BUF_B:    nxt_st.rdata = wide10(st_ff.buf_r[1]);
            ipw_pkg::ADDR_BUF_C:    nxt_st.rdata = wide10(st_ff.buf_r[2]);
            ipw_pkg::ADDR_BUF_P:    nxt_st.rdata = wide10(st_ff.buf_r[3]);
            ipw_pkg::ADDR_CMP_A:    nxt_st.rdata = wide10(st_ff.cmp[0]);
            ipw_pkg::ADDR_CMP_B:    nxt_st.rdata = wide10(st_ff.cmp[1]);
            ipw_pkg::ADDR_CMP_C:    nxt_st.rdata = wide10(st_ff.cmp[2]);
            ipw_pkg::ADDR_CMP_P:    nxt_st.rdata = wide10(st_ff.cmp[3]);
            ipw_pkg::ADDR_DEADTIME: nxt_st.rdata = {8'h00, st_ff.dead};
            default:                nxt_st.rdata = 16'h0000;
         endcase
      end

      // status flag: stop wins over a start in the same cycle
      if (stop_ev) begin
         nxt_st.status = 1'b0;
      end else if (run_start) begin
         nxt_st.status = 1'b1;
      end

      if (!run) begin
         // halted: counters cleared and held
         nxt_st.presc   = 5'h00;
         nxt_st.tri_cnt = 10'h000;
         nxt_st.up      = 1'b1;
         nxt_st.div_cnt = ipw_pkg::DIVCNT_RESET;
         if (!(reg_wr_in && reg_addr_in == ipw_pkg::ADDR_CMP_A)) begin
            nxt_st.cmp[0] = ipw_pkg::CMP_RESET;
         end
         if (!(reg_wr_in && reg_addr_in == ipw_pkg::ADDR_CMP_B)) begin
            nxt_st.cmp[1] = ipw_pkg::CMP_RESET;
         end
         if (!(reg_wr_in && reg_addr_in == ipw_pkg::ADDR_CMP_C)) begin
            nxt_st.cmp[2] = ipw_pkg::CMP_RESET;
         end
      end else begin
         // counting goes on regardless of the status flag
         nxt_st.presc = st_ff.presc + 5'h01;
         if (tick) begin
            if (st_ff.up) begin
               // turn at the period compare
               if (st_ff.tri_cnt == st_ff.cmp[ipw_pkg::PERIOD_IDX]) begin
                  nxt_st.up      = 1'b0;
                  nxt_st.tri_cnt = st_ff.tri_cnt - 10'h001;
               end else begin
                  nxt_st.tri_cnt = st_ff.tri_cnt + 10'h001;
               end
            end else if (st_ff.tri_cnt == 10'h000) begin
               nxt_st.up      = 1'b1;
               nxt_st.tri_cnt = 10'h001;
            end else begin
               nxt_st.tri_cnt = st_ff.tri_cnt - 10'h001;
            end
         end
         if (underflow) begin
            // interrupt thinning by the divide field
            nxt_st.div_cnt = st_ff.div_cnt + 3'h1;
            if (nxt_st.div_cnt == st_ff.ctrl[ipw_pkg::CTRL_DIV_LSB +: 3]) begin
               nxt_st.irq     = 1'b1;
               nxt_st.div_cnt = ipw_pkg::DIVCNT_RESET;
               nxt_st.cmp     = st_ff.buf_r;
            end
         end
      end

      // output drive, polarity and float
      for (int i = 0; i < 3; i++) begin
         nxt_st.pwm[2*i]   = pos_act[i] ~^ st_ff.mode[ipw_pkg::MODE_ALV_POS];
         nxt_st.pwm[2*i+1] = neg_act[i] ~^ st_ff.mode[ipw_pkg::MODE_ALV_POS];
      end
      nxt_st.oe = {6{nxt_st.ctrl[ipw_pkg::CTRL_RUN_POS] && nxt_st.status}};
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '{ctrl:    ipw_pkg::CTRL_RESET,
                    mode:    ipw_pkg::MODE_RESET,
                    status:  1'b0,
                    buf_r:   {ipw_pkg::PERIOD_RESET, ipw_pkg::CMP_RESET,
                              ipw_pkg::CMP_RESET, ipw_pkg::CMP_RESET},
                    cmp:     {ipw_pkg::PERIOD_RESET, ipw_pkg::CMP_RESET,
                              ipw_pkg::CMP_RESET, ipw_pkg::CMP_RESET},
                    dead:    ipw_pkg::DEADTIME_RESET,
                    presc:   5'h00,
                    tri_cnt: 10'h000,
                    up:      1'b1,
                    div_cnt: ipw_pkg::DIVCNT_RESET,
                    stop_s1: 1'b0,
                    stop_s2: 1'b0,
                    stop_s3: 1'b0,
                    irq:     1'b0,
                    rdata:   16'h0000,
                    pwm:     6'h00,
                    oe:      6'h00};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // positive phase active above the compare; above period never
   generate
      for (genvar i = 0; i < 3; i++) begin : g_chan
         assign want_pos[i] = st_ff.tri_cnt > st_ff.cmp[i];
         ipw_deadtime u_dead_time_counter (
            .sys_clk_in  (sys_clk_in),
            .arst_n_in   (arst_n_in),
            .run_in      (run),
            .want_pos_in (want_pos[i]),
            .reload_in   (st_ff.dead),
            .pos_act_out (pos_act[i]),
            .neg_act_out (neg_act[i])
         );
      end
   endgenerate

   assign reg_rdata_out        = st_ff.rdata;
   assign period_interrupt_out = st_ff.irq;
   assign phase_out            = st_ff.pwm;
   assign phase_oe_out         = st_ff.oe;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   halt_clears_a: assert property (!run |=> st_ff.tri_cnt == 10'h000
      && st_ff.div_cnt == ipw_pkg::DIVCNT_RESET)
      else $error("counters not cleared while halted");
   float_idle_a: assert property (!(run && st_ff.status)
      |=> phase_oe_out == 6'h00 || $past(reg_wr_in))
      else $error("outputs driven while not enabled");
   ext_stop_a: assert property (st_ff.mode[ipw_pkg::MODE_EXT_POS]
      && ext_edge |=> !st_ff.status ##1 phase_oe_out == 6'h00)
      else $error("external stop did not float outputs");
   wdt_stop_a: assert property (st_ff.mode[ipw_pkg::MODE_WDT_POS]
      && watchdog_interrupt_request_in |=> !st_ff.status)
      else $error("watchdog stop did not clear status");
   keep_running_a: assert property (run && !st_ff.status && tick
      && st_ff.up && st_ff.tri_cnt != st_ff.cmp[3]
      |=> st_ff.tri_cnt == $past(st_ff.tri_cnt) + 10'h001)
      else $error("counter stopped after forced stop");
   peak_turn_a: assert property (tick && st_ff.up
      && st_ff.tri_cnt == st_ff.cmp[3] |=> !st_ff.up)
      else $error("triangle did not turn at period compare");
   buffer_copy_a: assert property (nxt_st.irq
      |=> st_ff.cmp == $past(st_ff.buf_r) && period_interrupt_out)
      else $error("buffers not copied on period interrupt");
   flag_ro_a: assert property (reg_wr_in && reg_addr_in == ipw_pkg::ADDR_MODE
      && !st_ff.status && !run_start |=> !st_ff.status)
      else $error("software changed the status flag");
   over_period_a: assert property (run && st_ff.status
      && st_ff.mode[ipw_pkg::MODE_ALV_POS] && st_ff.cmp[0] > st_ff.cmp[3]
      && $stable(st_ff.cmp[0]) |=> !phase_out[0])
      else $error("positive phase active above period");
   slow_clock_a: assert property (run
      && st_ff.ctrl[ipw_pkg::CTRL_CLK_LSB +: 3] == 3'h1 && tick
      |=> !tick)
      else $error("divide by two clock ticked twice in a row");

   irq_seen_c: cover property (period_interrupt_out);
   ext_stop_c: cover property (st_ff.status ##1 !st_ff.status);
   turn_c: cover property (st_ff.up ##1 !st_ff.up);
   outputs_on_c: cover property (phase_oe_out == 6'h3f);
endmodule

// [hdl/ipw_pkg.sv]
// constants for the three-phase inverter pwm timer with dead time
package ipw_pkg;
   // register addresses
   localparam logic [15:0] ADDR_CTRL     = 16'hffa8;
   localparam logic [15:0] ADDR_MODE     = 16'hffa9;
   localparam logic [15:0] ADDR_BUF_A    = 16'hffb0;
   localparam logic [15:0] ADDR_BUF_B    = 16'hffb2;
   localparam logic [15:0] ADDR_BUF_C    = 16'hffb4;
   localparam logic [15:0] ADDR_BUF_P    = 16'hffb6;
   localparam logic [15:0] ADDR_CMP_A    = 16'hffb8;
   localparam logic [15:0] ADDR_CMP_B    = 16'hffba;
   localparam logic [15:0] ADDR_CMP_C    = 16'hffbc;
   localparam logic [15:0] ADDR_CMP_P    = 16'hffbe;
   localparam logic [15:0] ADDR_DEADTIME = 16'hffc0;
   // control register fields
   localparam int CTRL_RUN_POS  = 7;
   localparam int CTRL_CLK_LSB  = 3;
   localparam int CTRL_DIV_LSB  = 0;
   // mode register fields
   localparam int MODE_STAT_POS = 4;
   localparam int MODE_ALV_POS  = 3;
   localparam int MODE_EDGE_POS = 2;
   localparam int MODE_EXT_POS  = 1;
   localparam int MODE_WDT_POS  = 0;
   // reset values
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [3:0] MODE_RESET     = 4'h0;
   localparam logic [9:0] CMP_RESET      = 10'h000;
   localparam logic [9:0] PERIOD_RESET   = 10'h0ff;
   localparam logic [7:0] DEADTIME_RESET = 8'hff;
   localparam logic [2:0] DIVCNT_RESET   = 3'h7;
   localparam logic [7:0] DTCNT_IDLE     = 8'hff;
   // index of the period compare among the four compares
   localparam int PERIOD_IDX = 3;
endpackage

// [hdl/ipw_deadtime.sv]
// one channel: dead-time counter and complementary phase drive
`timescale 1ns/1ps
module ipw_deadtime (
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       arst_n_in,
   // control
   input  wire logic       run_in,
   input  wire logic       want_pos_in,
   input  wire logic [7:0] reload_in,
   // phase drive, high means active
   output logic            pos_act_out,
   output logic            neg_act_out
);
   typedef struct packed {
      logic       phase;
      logic       done;
      logic [7:0] cnt;
   } ipw_dt_state_t;

   ipw_dt_state_t st_ff;
   ipw_dt_state_t nxt_st;
   logic          expired;

   // the last count at zero already ends the gap, so that the reload
   // one cycle after the switch still gives reload plus one
   assign expired = st_ff.done | (st_ff.cnt == 8'h00);

   always_comb begin
      nxt_st = st_ff;
      if (!run_in) begin
         nxt_st.phase = 1'b0;
         nxt_st.done  = 1'b1;
         nxt_st.cnt   = ipw_pkg::DTCNT_IDLE;
      end else if (want_pos_in != st_ff.phase) begin
         // reload on every switching point
         nxt_st.phase = want_pos_in;
         nxt_st.done  = 1'b0;
         nxt_st.cnt   = reload_in;
      end else if (!st_ff.done) begin
         // 00 wraps to ff and the counter parks there
         nxt_st.cnt = st_ff.cnt - 8'h01;
         if (st_ff.cnt == 8'h00) begin
            nxt_st.done = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '{phase: 1'b0, done: 1'b1, cnt: ipw_pkg::DTCNT_IDLE};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // the leaving side drops at once, the other waits for expiry
   assign pos_act_out = st_ff.phase & expired & (want_pos_in == st_ff.phase);
   assign neg_act_out = ~st_ff.phase & expired & (want_pos_in == st_ff.phase);

   default clocking dcb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   switch_off_a: assert property (run_in && (want_pos_in != st_ff.phase)
      |-> !pos_act_out && !neg_act_out)
      else $error("phase output active at a switching point");
   dead_span_a: assert property (run_in && (want_pos_in != st_ff.phase)
      && reload_in == 8'h02 ##1 (run_in && want_pos_in == st_ff.phase)[*2]
      |-> !pos_act_out && !neg_act_out)
      else $error("dead time shorter than reload plus one");
endmodule

// [testbench/ipw_stage_model.sv]
// far-side model: power stage pins, shoot-through watch, stop input source
`timescale 1ns/1ps
module ipw_stage_model (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        arst_n_in,
   // timer side
   input  wire logic [5:0]  phase_in,
   input  wire logic [5:0]  phase_oe_in,
   input  wire logic        alv_in,
   input  wire logic        stop_level_in,
   output logic             output_stop_out,
   // observed pins and overlap count
   output logic      [5:0]  pin_out,
   output logic      [15:0] overlap_cnt_out
);
   logic [5:0] last_ff;
   logic [5:0] act;
   assign output_stop_out = stop_level_in;
   // a floated pin has no keeper: it toggles away from its last level
   assign pin_out = (phase_oe_in & phase_in) | (~phase_oe_in & ~last_ff);
   assign act = phase_oe_in & ~(phase_in ^ {6{alv_in}});
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         last_ff         <= 6'h00;
         overlap_cnt_out <= 16'h0000;
      end else begin
         last_ff <= pin_out;
         if ((act[0] & act[1]) | (act[2] & act[3]) | (act[4] & act[5])) begin
            overlap_cnt_out <= overlap_cnt_out + 16'h0001;
         end
      end
   end
endmodule

// [testbench/tb.sv]
// self-checking bench for the inverter pwm timer
`timescale 1ns/1ps
module tb;
   typedef struct {
      logic [15:0] addr;
      logic        wr;
      logic [15:0] data;
      logic [15:0] exp;
   } ipw_row_t;
   typedef struct {
      logic [3:0] mode;
      logic       wdt;
      logic       stop;
   } ipw_stop_t;
   logic        sys_clk;
   logic        arst_n;
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        stop_pin;
   logic        stop_level;
   logic        wdt_req;
   logic        irq;
   logic [5:0]  phase;
   logic [5:0]  phase_oe;
   logic [5:0]  pins;
   logic [15:0] overlaps;
   logic        active_level_select;
   int          err_total;
   int          samples_checked;
   ipw_row_t    rows [12];
   ipw_stop_t   stops [5];

   ipw_timer uut (
      .sys_clk_in(sys_clk),
      .arst_n_in(arst_n),
      .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata),
      .output_stop_input_in(stop_pin),
      .watchdog_interrupt_request_in(wdt_req),
      .period_interrupt_out(irq),
      .phase_out(phase),
      .phase_oe_out(phase_oe)
   );

   ipw_stage_model model (
      .sys_clk_in(sys_clk),
      .arst_n_in(arst_n),
      .phase_in(phase),
      .phase_oe_in(phase_oe),
      .alv_in(active_level_select),
      .stop_level_in(stop_level),
      .output_stop_out(stop_pin),
      .pin_out(pins),
      .overlap_cnt_out(overlaps)
   );

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen,
                      input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge sys_clk);
   endtask

   task automatic wait_irq(output int n);
      n = 0;
      do begin
         tick();
         n++;
      end while (irq !== 1'b1 && n < 5000);
   endtask

   task automatic wait_pin(input int idx, input logic v, output int n);
      n = 0;
      while (phase[idx] !== v && n < 100) begin
         tick();
         n++;
      end
   endtask

   // halt, clear, reload, then start with a run-only write
   task automatic start_pwm(input logic [3:0] mode, input logic [7:0] cfg,
                            input logic [9:0] cmp);
      wr(ipw_pkg::ADDR_CTRL, 16'h0000);
      wr(ipw_pkg::ADDR_MODE, {12'h000, mode});
      active_level_select <= mode[3];
      wr(ipw_pkg::ADDR_CMP_P, 16'h0008);
      wr(ipw_pkg::ADDR_BUF_P, 16'h0008);
      wr(ipw_pkg::ADDR_DEADTIME, 16'h0002);
      for (int i = 0; i < 3; i++) begin
         wr(ipw_pkg::ADDR_CMP_A + 16'(2 * i), {6'h00, cmp});
         wr(ipw_pkg::ADDR_BUF_A + 16'(2 * i), {6'h00, cmp});
      end
      wr(ipw_pkg::ADDR_CTRL, {8'h00, cfg});
      wr(ipw_pkg::ADDR_CTRL, {8'h00, cfg | 8'h80});
   endtask

   initial begin
      repeat (80000) @(posedge sys_clk);
      err_total++;
      finish_test();
   end

   initial begin
      int          n;
      logic [15:0] d;
      logic        bad;
      rows = '{
         '{ipw_pkg::ADDR_CTRL,     1'b0, 16'h0000, 16'h0000},
         '{ipw_pkg::ADDR_MODE,     1'b0, 16'h0000, 16'h0000},
         '{ipw_pkg::ADDR_CMP_P,    1'b0, 16'h0000, 16'h00ff},
         '{ipw_pkg::ADDR_BUF_P,    1'b0, 16'h0000, 16'h00ff},
         '{ipw_pkg::ADDR_DEADTIME, 1'b0, 16'h0000, 16'h00ff},
         '{ipw_pkg::ADDR_BUF_A,    1'b0, 16'h0000, 16'h0000},
         '{ipw_pkg::ADDR_MODE,     1'b1, 16'h00ff, 16'h0000},
         '{ipw_pkg::ADDR_MODE,     1'b0, 16'h0000, 16'h000f},
         '{ipw_pkg::ADDR_CTRL,     1'b1, 16'h007f, 16'h0000},
         '{ipw_pkg::ADDR_CTRL,     1'b0, 16'h0000, 16'h003f},
         '{16'hffa0,               1'b0, 16'h0000, 16'h0000},
         '{ipw_pkg::ADDR_CTRL,     1'b1, 16'h0000, 16'h0000}};
      stops = '{'{4'b1110, 1'b0, 1'b1}, '{4'b1010, 1'b0, 1'b1},
                '{4'b1100, 1'b0, 1'b0}, '{4'b1001, 1'b1, 1'b1},
                '{4'b1000, 1'b1, 1'b0}};
      err_total       = 0;
      samples_checked = 0;
      arst_n     <= 1'b0;
      reg_addr   <= 16'h0000;
      reg_wdata  <= 16'h0000;
      reg_wr     <= 1'b0;
      reg_rd     <= 1'b0;
      stop_level <= 1'b0;
      wdt_req    <= 1'b0;
      active_level_select        <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk("oe_reset", {10'h000, phase_oe}, 16'h0000);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].addr, rows[i].data);
         end else begin
            rd(rows[i].addr, d);
            chk("reg_read", d, rows[i].exp);
         end
      end
      for (int s = 0; s < 6; s++) begin
         logic [2:0] dv;
         dv = 3'((s * 3 + 7) % 8);
         start_pwm(4'b1000, {2'b00, 3'(s), dv}, 10'h003);
         wait_irq(n);
         wait_irq(n);
         d = 16'((16 << s) * (int'(dv) + 1));
         chk("irq_spacing", 16'(n), d);
      end
      start_pwm(4'b1000, 8'h00, 10'h003);
      wait_pin(0, 1'b1, n);
      wait_pin(0, 1'b0, n);
      wait_pin(1, 1'b1, n);
      chk("dead_gap", 16'(n), 16'h0003);
      wr(ipw_pkg::ADDR_BUF_P, 16'h0004);
      wr(ipw_pkg::ADDR_CMP_P, 16'h0014);
      wait_irq(n);
      wait_irq(n);
      wait_irq(n);
      chk("copied_period", 16'(n), 16'h0008);
      rd(ipw_pkg::ADDR_CMP_P, d);
      chk("cmp_copied", d, 16'h0004);
      for (int a = 0; a < 2; a++) begin
         start_pwm({a[0], 3'b000}, 8'h00, 10'h3ff);
         repeat (40) tick();
         bad = 1'b0;
         repeat (32) begin
            tick();
            bad |= (pins[1:0] !== (a[0] ? 2'b10 : 2'b01));
         end
         chk("fixed_levels", {15'h0000, bad}, 16'h0000);
      end
      foreach (stops[i]) begin
         stop_level <= ~stops[i].mode[2];
         start_pwm(stops[i].mode, 8'h00, 10'h003);
         repeat (8) tick();
         chk("oe_run", {10'h000, phase_oe}, 16'h003f);
         if (stops[i].wdt) begin
            wdt_req <= 1'b1;
            tick();
            wdt_req <= 1'b0;
         end else begin
            stop_level <= stops[i].mode[2];
            repeat (3) tick();
            stop_level <= ~stops[i].mode[2];
         end
         repeat (8) tick();
         d = stops[i].stop ? 16'h0000 : 16'h003f;
         chk("oe_stop", {10'h000, phase_oe}, d);
         rd(ipw_pkg::ADDR_MODE, d);
         chk("status", d, {11'h000, ~stops[i].stop, stops[i].mode});
         wait_irq(n);
         chk("irq_runs", 16'(n < 5000), 16'h0001);
      end
      wr(ipw_pkg::ADDR_CTRL, 16'h0000);
      tick();
      chk("oe_halt", {10'h000, phase_oe}, 16'h0000);
      chk("overlap", overlaps, 16'h0000);
      finish_test();
   end
endmodule
